// ==== hdl/adc_trigger_queue_cfg.svh ====
// Function
// - A qualifying write to the convert-strobe port requests one conversion; the data is dropped.
// - Strobe converts only with pacer source 00, conversions enabled, window select 0.
// - Queue entry: gain line bit 10, gain code bits 9:8, channel bits 7:0.
// - Gain line bit of the selected entry drives the external gain output.
// - Gain code gives 1,5,50,250 on high-gain or 1,2,4,8 on low-gain.
// - Channel range 15/7 without expansion, 255/127 with, single-ended/differential.
// - Queue location is start address minus decrements since the load.
// - Select 0: data read, strobe write; select 1: queue data both ways.
// - Window select register clears to 00h at reset.
// - Trigger control register clears to 00h at reset, everything disabled.
// - Control bits 7..0: about, polarity, trig/gate, ext enable, gate src, gate, S/H, FIFO.
// - About-trigger: counter 0 loads, counts down, stops at zero, interrupts if enabled.
// - Ext trigger on in edge mode: first edge starts, second loads; otherwise: start now, first edge loads.
// - Polarity 0: falling edge or low gate; polarity 1: rising edge or high gate.
// - Trig/gate select: 0 edge trigger, 1 level gate; no effect with ext trigger off.
// - External trigger enable only connects trigger input; never gates pacer counters.
// - Gate source 0: pacer counts while gate bit 1; 1: while trigger input active.
// - Internal gate bit ignored when gate source is not 0.
// - Sample-and-hold enable turns external sample-and-hold cooperation on or off.
// - FIFO pointer enable 0 holds pointers in reset; 1 lets them run.
// - Pacer source: 00 software, 01 internal, 10 ext rising, 11 ext falling.
`ifndef ADC_TRIGGER_QUEUE_CFG_SVH
`define ADC_TRIGGER_QUEUE_CFG_SVH

`define OFS_SHARED 3'h0
`define OFS_SELECT 3'h2
`define OFS_CONTROL 3'h4

`define SELECT_RESET 1'h0
`define CONTROL_RESET 8'h00

`define PACER_SOFTWARE 2'h0
`define PACER_INTERNAL 2'h1
`define PACER_EXT_RISE 2'h2
`define PACER_EXT_FALL 2'h3

`define QUEUE_DEPTH 256

`endif

// ==== hdl/adc_trigger_queue_pkg.sv ====
package adc_trigger_queue_pkg;

  // Bit 7 down to bit 0 of the trigger/gate control register
  typedef struct packed {
    logic aboutTriggerEnable;
    logic triggerPolarity;
    logic triggerOrGateSelect;
    logic externalTriggerEnable;
    logic pacerGateSource;
    logic pacerGateBit;
    logic sampleHoldEnable;
    logic fifoPointerEnable;
  } trig_ctrl_t;

  typedef struct packed {
    logic externalGainLine;
    logic [1:0] gainCode;
    logic [7:0] channelNumber;
  } queue_entry_t;

  typedef enum logic [2:0] {
    ACQ_IDLE,
    ACQ_WAIT_START,
    ACQ_RUN,
    ACQ_POST,
    ACQ_STOP
  } acq_state_t;

endpackage

// ==== hdl/adc_trigger_queue_control.sv ====
`timescale 1ns/1ps
`include "adc_trigger_queue_cfg.svh"

module adc_trigger_queue_control #(
  parameter bit HIGH_GAIN_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  // Host I/O bus
  input wire logic [2:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioWrData,
  output logic [15:0] ioRdData,
  output logic ioRdValid,
  // Settings held elsewhere on the board
  input wire logic [1:0] pacerSourceSelect,
  input wire logic conversionEnable,
  input wire logic singleEndedMode,
  input wire logic expansionPresent,
  input wire logic interruptLevelEnabled,
  input wire logic [15:0] adcFifoData,
  // Queue address control
  input wire logic [7:0] queueStartAddr,
  input wire logic queueStartLoad,
  input wire logic queueDecrement,
  // Post-trigger counter and internal pacer
  input wire logic [15:0] postTriggerCount,
  input wire logic internalPacerTick,
  // Connector pins
  input wire logic triggerGateInput,
  input wire logic externalPacerInput,
  output logic externalGainLine,
  // Converter side
  output logic convertRequest,
  output logic [1:0] gainCode,
  output logic [7:0] gainFactor,
  output logic [7:0] channelNumber,
  output logic channelInRange,
  output logic pacerCountEnable,
  output logic sampleHoldEnable,
  output logic fifoPointerReset,
  output logic postTriggerIrq,
  output logic postTriggerDone
);

  function automatic logic [7:0] gainOf(input logic [1:0] code, input logic highVariant);
    logic [7:0] g;
    g = 8'h01;
    case (code)
      2'h0: g = 8'h01;
      2'h1: g = highVariant ? 8'h05 : 8'h02;
      2'h2: g = highVariant ? 8'h32 : 8'h04;
      default: g = highVariant ? 8'hfa : 8'h08;
    endcase
    return g;
  endfunction

  function automatic logic channelOk(input logic [7:0] ch, input logic se, input logic ex);
    logic [7:0] maxCh;
    maxCh = 8'h0f;
    if (ex)
      maxCh = se ? 8'hff : 8'h7f;
    else
      maxCh = se ? 8'h0f : 8'h07;
    return ch <= maxCh;
  endfunction

  adc_trigger_queue_pkg::trig_ctrl_t ctrl_q;
  adc_trigger_queue_pkg::queue_entry_t queueMem [`QUEUE_DEPTH];
  adc_trigger_queue_pkg::queue_entry_t entry_q;
  adc_trigger_queue_pkg::acq_state_t state_q;
  logic windowSelect_q;
  logic [7:0] queueAddr_q;
  logic [15:0] rdData_q;
  logic rdValid_q;
  logic trigSync1_q, trigSync2_q, trigPrev_q;
  logic pacerSync1_q, pacerSync2_q, pacerPrev_q;
  logic [15:0] postCount_q;
  logic convReq_q;
  logic pacerGate_q;
  logic irq_q;
  logic done_q;

  logic sharedWrite, sharedRead, swStart, hwStart, srcEvent;
  logic trigActive, trigEdge, gateOk, loadPost, postHit;

  assign sharedWrite = ioWrite && (ioAddr == `OFS_SHARED);
  assign sharedRead = ioRead && (ioAddr == `OFS_SHARED);

  // Host register writes
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      windowSelect_q <= `SELECT_RESET;
      ctrl_q <= `CONTROL_RESET;
    end
    else if (clockEnable && ioWrite)
    begin
      if (ioAddr == `OFS_SELECT)
        windowSelect_q <= ioWrData[0];
      else if (ioAddr == `OFS_CONTROL)
        ctrl_q <= ioWrData[7:0];
    end
  end

  // Queue address: start minus decrements since the last load
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      queueAddr_q <= 8'h00;
    else if (clockEnable)
    begin
      if (queueStartLoad)
        queueAddr_q <= queueStartAddr;
      else if (queueDecrement)
        queueAddr_q <= queueAddr_q - 8'h01;
    end
  end

  // Queue storage has no reset; the host fills it before use
  always_ff @(posedge clock)
  begin
    if (clockEnable && sharedWrite && windowSelect_q)
      queueMem[queueAddr_q] <= ioWrData[10:0];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      entry_q <= '0;
    else if (clockEnable)
      entry_q <= queueMem[queueAddr_q];
  end

  assign externalGainLine = entry_q.externalGainLine;
  assign gainCode = entry_q.gainCode;
  assign channelNumber = entry_q.channelNumber;
  assign gainFactor = gainOf(entry_q.gainCode, HIGH_GAIN_VARIANT);
  assign channelInRange = channelOk(entry_q.channelNumber, singleEndedMode, expansionPresent);

  // Host register reads, answered one cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      rdValid_q <= ioRead;
      if (ioRead)
      begin
        if (ioAddr == `OFS_SHARED)
          rdData_q <= windowSelect_q ? {5'h00, entry_q} : adcFifoData;
        else if (ioAddr == `OFS_SELECT)
          rdData_q <= {15'h0000, windowSelect_q};
        else if (ioAddr == `OFS_CONTROL)
          rdData_q <= {8'h00, ctrl_q};
        else
          rdData_q <= 16'h0000;
      end
    end
  end

  assign ioRdData = rdData_q;
  assign ioRdValid = rdValid_q;

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trigSync1_q <= 1'b0;
      trigSync2_q <= 1'b0;
      trigPrev_q <= 1'b0;
      pacerSync1_q <= 1'b0;
      pacerSync2_q <= 1'b0;
      pacerPrev_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      trigSync1_q <= triggerGateInput;
      trigSync2_q <= trigSync1_q;
      trigPrev_q <= trigSync2_q;
      pacerSync1_q <= externalPacerInput;
      pacerSync2_q <= pacerSync1_q;
      pacerPrev_q <= pacerSync2_q;
    end
  end

  assign trigActive = (trigSync2_q == ctrl_q.triggerPolarity);
  assign trigEdge = trigActive && (trigPrev_q != ctrl_q.triggerPolarity);

  // Software strobe: data ignored, dropped unless every condition holds
  assign swStart = sharedWrite && !windowSelect_q && conversionEnable
                   && (pacerSourceSelect == `PACER_SOFTWARE);

  always_comb
  begin
    srcEvent = 1'b0;
    case (pacerSourceSelect)
      `PACER_INTERNAL: srcEvent = internalPacerTick;
      `PACER_EXT_RISE: srcEvent = pacerSync2_q && !pacerPrev_q;
      `PACER_EXT_FALL: srcEvent = !pacerSync2_q && pacerPrev_q;
      default: srcEvent = 1'b0;
    endcase
  end

  // Level gate only applies with the trigger input enabled in gate mode
  assign gateOk = !(ctrl_q.externalTriggerEnable && ctrl_q.triggerOrGateSelect) || trigActive;
  assign hwStart = conversionEnable && srcEvent && gateOk
                   && ((state_q == adc_trigger_queue_pkg::ACQ_RUN) || (state_q == adc_trigger_queue_pkg::ACQ_POST));
  assign loadPost = (state_q == adc_trigger_queue_pkg::ACQ_RUN) && ctrl_q.aboutTriggerEnable && trigEdge;
  assign postHit = (state_q == adc_trigger_queue_pkg::ACQ_POST) && (postCount_q == 16'h0000);

  // Acquisition sequencing
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state_q <= adc_trigger_queue_pkg::ACQ_IDLE;
    else if (clockEnable)
    begin
      if (!conversionEnable)
        state_q <= adc_trigger_queue_pkg::ACQ_IDLE;
      else
      begin
        case (state_q)
          adc_trigger_queue_pkg::ACQ_IDLE:
            if (ctrl_q.externalTriggerEnable && !ctrl_q.triggerOrGateSelect)
              state_q <= adc_trigger_queue_pkg::ACQ_WAIT_START;
            else
              state_q <= adc_trigger_queue_pkg::ACQ_RUN;
          adc_trigger_queue_pkg::ACQ_WAIT_START:
            if (trigEdge)
              state_q <= adc_trigger_queue_pkg::ACQ_RUN;
          adc_trigger_queue_pkg::ACQ_RUN:
            if (loadPost)
              state_q <= adc_trigger_queue_pkg::ACQ_POST;
          adc_trigger_queue_pkg::ACQ_POST:
            if (postHit)
              state_q <= adc_trigger_queue_pkg::ACQ_STOP;
          default:
            state_q <= adc_trigger_queue_pkg::ACQ_STOP;
        endcase
      end
    end
  end

  // Post-trigger counter counts converted samples
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      postCount_q <= 16'h0000;
    else if (clockEnable)
    begin
      if (loadPost)
        postCount_q <= postTriggerCount;
      else if (hwStart && (state_q == adc_trigger_queue_pkg::ACQ_POST) && (postCount_q != 16'h0000))
        postCount_q <= postCount_q - 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      done_q <= postHit;
      irq_q <= postHit && interruptLevelEnabled;
    end
  end

  assign postTriggerDone = done_q;
  assign postTriggerIrq = irq_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      convReq_q <= 1'b0;
    else if (clockEnable)
      convReq_q <= swStart || (hwStart && !postHit);
  end

  assign convertRequest = convReq_q;

  // Pacer gate: external enable plays no part here
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pacerGate_q <= 1'b0;
    else if (clockEnable)
      pacerGate_q <= ctrl_q.pacerGateSource ? trigActive : ctrl_q.pacerGateBit;
  end

  assign pacerCountEnable = pacerGate_q;
  assign sampleHoldEnable = ctrl_q.sampleHoldEnable;
  assign fifoPointerReset = !ctrl_q.fifoPointerEnable;

  chk_strobe_converts: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && sharedWrite && !windowSelect_q && conversionEnable && pacerSourceSelect == 2'h0
    |=> convertRequest)
    else $error("strobe write did not request a conversion");

  chk_strobe_dropped: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && sharedWrite && (windowSelect_q || !conversionEnable) && !hwStart
    |=> !convertRequest)
    else $error("strobe with unmet condition converted");

  chk_strobe_pacer: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && sharedWrite && pacerSourceSelect != 2'h0 && !hwStart |=> !convertRequest)
    else $error("strobe converted with non-software pacer");

  chk_queue_addr: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && queueDecrement && !queueStartLoad |=> queueAddr_q == $past(queueAddr_q) - 8'h01)
    else $error("queue address did not decrement");

  chk_queue_roundtrip: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && sharedWrite && windowSelect_q && !queueStartLoad && !queueDecrement
    ##1 clockEnable && !queueStartLoad && !queueDecrement
    |=> entry_q == $past(ioWrData[10:0], 2))
    else $error("queue entry not stored");

  // The pin must match what the host reads back from the same entry
  chk_gain_line: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && sharedRead && windowSelect_q |=> ioRdData[10:8] == $past({externalGainLine, gainCode}))
    else $error("gain outputs differ from entry");

  chk_ctrl_reset: assert property (@(posedge clock)
    $past(sys_rst) |-> ctrl_q == 8'h00 && !windowSelect_q && fifoPointerReset)
    else $error("control not cleared by reset");

  chk_pacer_gate: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && !ctrl_q.pacerGateSource && $stable(ctrl_q) |=> pacerCountEnable == $past(ctrl_q.pacerGateBit))
    else $error("internal pacer gate not followed");

  chk_post_stop: assert property (@(posedge clock) disable iff (sys_rst)
    clockEnable && postHit && conversionEnable |=> postTriggerDone ##0 state_q == adc_trigger_queue_pkg::ACQ_STOP)
    else $error("post-trigger count end did not stop");

  chk_wait_edge: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == adc_trigger_queue_pkg::ACQ_WAIT_START |-> !convertRequest || $past(swStart))
    else $error("conversion before first trigger edge");

endmodule

// ==== dv/host_io_model.sv ====
`timescale 1ns/1ps
module host_io_model (
  // Clock
  input wire logic clock,
  // Bus toward the device
  output logic [2:0] ioAddr,
  output logic ioWrite,
  output logic ioRead,
  output logic [15:0] ioWrData,
  // Answer from the device
  input wire logic [15:0] ioRdData,
  input wire logic ioRdValid
);
  initial
  begin
    ioAddr = 3'h7;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWrData = 16'h5a5a;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one
  task automatic busWrite(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    ioAddr <= a;
    ioWrData <= d;
    ioWrite <= 1'b1;
    @(posedge clock);
    ioWrite <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~d;
  endtask

  // Answer stands one cycle only, so it is taken just after the accepting edge
  task automatic busRead(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge clock);
    ioRead <= 1'b0;
    ioAddr <= ~a;
    #1;
    d = (ioRdValid === 1'b1) ? ioRdData : 16'hxxxx;
  endtask
endmodule

// ==== dv/adc_trigger_queue_control_test.sv ====
`timescale 1ns/1ps
module adc_trigger_queue_control_test;
  typedef struct packed {
    logic [1:0] pacer;
    logic conversion_enable;
    logic sel;
    logic conv;
  } strobe_row_t;
  strobe_row_t rows[6] = '{'{2'h0, 1'b1, 1'b0, 1'b1}, '{2'h1, 1'b1, 1'b0, 1'b0}, '{2'h2, 1'b1, 1'b0, 1'b0},
    '{2'h3, 1'b1, 1'b0, 1'b0}, '{2'h0, 1'b1, 1'b1, 1'b0}, '{2'h0, 1'b0, 1'b0, 1'b0}};
  logic clock, sys_rst, ioWrite, ioRead, ioRdValid, queueStartLoad, queueDecrement, internalPacerTick;
  logic [2:0] ioAddr;
  logic [15:0] ioWrData, ioRdData;
  logic [1:0] pacerSourceSelect, gainCode;
  logic conversionEnable, singleEndedMode, expansionPresent, triggerGateInput, externalGainLine;
  logic externalPacerInput, interruptLevelEnabled;
  logic [7:0] queueStartAddr, gainFactor, channelNumber;
  logic convertRequest, channelInRange, pacerCountEnable, sampleHoldEnable, fifoPointerReset;
  logic postTriggerIrq, postTriggerDone;
  int failures = 0, totalChecks = 0, convCount = 0, doneCount = 0, irqCount = 0, cycles = 0;

  adc_trigger_queue_control i_dut (.clock(clock), .sys_rst(sys_rst), .clockEnable(1'b1), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .pacerSourceSelect(pacerSourceSelect), .conversionEnable(conversionEnable),
    .singleEndedMode(singleEndedMode), .expansionPresent(expansionPresent),
    .interruptLevelEnabled(interruptLevelEnabled),
    .adcFifoData(16'h0bcd), .queueStartAddr(queueStartAddr), .queueStartLoad(queueStartLoad),
    .queueDecrement(queueDecrement), .postTriggerCount(16'h0003), .internalPacerTick(internalPacerTick),
    .triggerGateInput(triggerGateInput), .externalPacerInput(externalPacerInput),
    .externalGainLine(externalGainLine),
    .convertRequest(convertRequest), .gainCode(gainCode), .gainFactor(gainFactor),
    .channelNumber(channelNumber), .channelInRange(channelInRange), .pacerCountEnable(pacerCountEnable),
    .sampleHoldEnable(sampleHoldEnable), .fifoPointerReset(fifoPointerReset),
    .postTriggerIrq(postTriggerIrq), .postTriggerDone(postTriggerDone));

  host_io_model i_host (.clock(clock), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock)
  begin
    convCount <= convCount + (convertRequest === 1'b1 ? 1 : 0);
    doneCount <= doneCount + (postTriggerDone === 1'b1 ? 1 : 0);
    irqCount <= irqCount + (postTriggerIrq === 1'b1 ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic tick;
    @(posedge clock);
    internalPacerTick <= 1'b1;
    @(posedge clock);
    internalPacerTick <= 1'b0;
    cyc(3);
  endtask

  // Sequencer restarted from idle, one tick before and one after the trigger pin changes
  task automatic tryStart(input logic [7:0] ctrl, input logic idle, input logic act);
    int base;
    @(posedge clock);
    conversionEnable <= 1'b0;
    triggerGateInput <= idle;
    pacerSourceSelect <= 2'h1;
    i_host.busWrite(3'h4, {8'h00, ctrl});
    conversionEnable <= 1'b1;
    cyc(4);
    base = convCount;
    tick();
    check("start before trigger", 16'(convCount - base), 16'h0000);
    triggerGateInput <= act;
    cyc(6);
    tick();
    check("start after trigger", 16'(convCount - base), 16'h0001);
  endtask

  // Sequencer already running; one pulse on the external pacer pin
  task automatic pacerEdge(input logic [1:0] src, input logic [15:0] afterRise);
    int base;
    @(posedge clock);
    pacerSourceSelect <= src;
    cyc(3);
    base = convCount;
    externalPacerInput <= 1'b1;
    cyc(6);
    check("pacer rise", 16'(convCount - base), afterRise);
    externalPacerInput <= 1'b0;
    cyc(6);
    check("pacer fall", 16'(convCount - base), 16'h0001);
  endtask

  // About-trigger with software start: one sample before the edge, three after
  task automatic aboutRun(input logic irqOn);
    int base, doneBase, irqBase;
    @(posedge clock);
    conversionEnable <= 1'b0;
    triggerGateInput <= 1'b0;
    pacerSourceSelect <= 2'h1;
    interruptLevelEnabled <= irqOn;
    i_host.busWrite(3'h4, 16'h00c4);
    conversionEnable <= 1'b1;
    cyc(4);
    base = convCount;
    doneBase = doneCount;
    irqBase = irqCount;
    tick();
    triggerGateInput <= 1'b1;
    cyc(6);
    tick();
    tick();
    check("not done early", 16'(doneCount - doneBase), 16'h0000);
    tick();
    check("done", 16'(doneCount - doneBase), 16'h0001);
    check("irq", 16'(irqCount - irqBase), {15'h0, irqOn});
    tick();
    check("conversions stop", 16'(convCount - base), 16'h0004);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    logic [15:0] rd;
    int base;
    sys_rst = 1'b1;
    pacerSourceSelect = 2'h0;
    conversionEnable = 1'b0;
    singleEndedMode = 1'b1;
    expansionPresent = 1'b0;
    queueStartAddr = 8'h00;
    queueStartLoad = 1'b0;
    queueDecrement = 1'b0;
    internalPacerTick = 1'b0;
    triggerGateInput = 1'b0;
    externalPacerInput = 1'b0;
    interruptLevelEnabled = 1'b1;
    cyc(16);
    sys_rst <= 1'b0;
    i_host.busRead(3'h4, rd);
    check("control reset", rd, 16'h0000);
    i_host.busRead(3'h2, rd);
    check("select reset", rd, 16'h0000);
    check("fifo held", {15'h0, fifoPointerReset}, 16'h0001);
    foreach (rows[i])
    begin
      @(posedge clock);
      pacerSourceSelect <= rows[i].pacer;
      conversionEnable <= rows[i].conversion_enable;
      i_host.busWrite(3'h2, {15'h0, rows[i].sel});
      base = convCount;
      i_host.busWrite(3'h0, 16'hffff);
      cyc(3);
      check("strobe", 16'(convCount - base), {15'h0, rows[i].conv});
    end
    i_host.busRead(3'h0, rd);
    check("fifo data", rd, 16'h0bcd);
    i_host.busWrite(3'h6, 16'hffff);
    i_host.busRead(3'h6, rd);
    check("unmapped", rd, 16'h0000);
    i_host.busWrite(3'h4, 16'h009d);
    i_host.busRead(3'h4, rd);
    check("control", rd, 16'h009d);
    check("fifo run", {15'h0, fifoPointerReset}, 16'h0000);
    i_host.busWrite(3'h4, 16'h0002);
    cyc(1);
    check("sample hold", {14'h0, sampleHoldEnable, fifoPointerReset}, 16'h0003);
    i_host.busWrite(3'h4, 16'h0004);
    cyc(2);
    check("gate bit on", {15'h0, pacerCountEnable}, 16'h0001);
    i_host.busWrite(3'h4, 16'h0010);
    cyc(2);
    check("ext enable no gate", {15'h0, pacerCountEnable}, 16'h0000);
    i_host.busWrite(3'h4, 16'h004c);
    cyc(5);
    check("pin gate idle", {15'h0, pacerCountEnable}, 16'h0000);
    triggerGateInput <= 1'b1;
    cyc(5);
    check("pin gate active", {15'h0, pacerCountEnable}, 16'h0001);
    @(posedge clock);
    queueStartAddr <= 8'h05;
    queueStartLoad <= 1'b1;
    @(posedge clock);
    queueStartLoad <= 1'b0;
    conversionEnable <= 1'b0;
    i_host.busWrite(3'h2, 16'h0001);
    i_host.busWrite(3'h0, 16'hf6a5);
    cyc(3);
    check("entry", {5'h0, externalGainLine, gainCode, channelNumber}, 16'h06a5);
    check("gain 50", {8'h0, gainFactor}, 16'h0032);
    check("range", {15'h0, channelInRange}, 16'h0000);
    expansionPresent <= 1'b1;
    cyc(1);
    check("range expanded", {15'h0, channelInRange}, 16'h0001);
    singleEndedMode <= 1'b0;
    cyc(1);
    check("range differential", {15'h0, channelInRange}, 16'h0000);
    queueDecrement <= 1'b1;
    @(posedge clock);
    queueDecrement <= 1'b0;
    i_host.busWrite(3'h0, 16'h0312);
    cyc(3);
    check("entry lower", {externalGainLine, gainCode, channelNumber, 5'h0}, 16'h6240);
    check("gain 250", {8'h0, gainFactor}, 16'h00fa);
    queueStartLoad <= 1'b1;
    @(posedge clock);
    queueStartLoad <= 1'b0;
    cyc(3);
    i_host.busRead(3'h0, rd);
    check("entry reload", rd, 16'h06a5);
    i_host.busWrite(3'h2, 16'h0000);
    tryStart(8'h34, 1'b1, 1'b0);
    tryStart(8'h54, 1'b0, 1'b1);
    pacerEdge(2'h2, 16'h0001);
    pacerEdge(2'h3, 16'h0000);
    aboutRun(1'b1);
    aboutRun(1'b0);
    i_host.busWrite(3'h4, 16'h00df);
    i_host.busRead(3'h4, rd);
    check("control before reset", rd, 16'h00df);
    @(posedge clock);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    i_host.busRead(3'h4, rd);
    check("control system reset", rd, 16'h0000);
    check("fifo held again", {15'h0, fifoPointerReset}, 16'h0001);
    tally_and_finish();
  end
endmodule
